// ==== pkg/smp_pkg.sv ====
// shared constants of the shared-memory core protection block
// assumes a 32-bit classic wishbone register bus on one 100 MHz clock
package smp_pkg;
  // ----------------------------------------------------------------
  // register bus
  // ----------------------------------------------------------------
  localparam int unsigned ADR_W = 18;
  localparam int unsigned DAT_W = 32;
  // register indices as printed, byte address is four times the index
  localparam logic [15:0] IDX_CTRL = 16'hF900;
  localparam logic [15:0] IDX_TOP = 16'hF902;
  localparam logic [15:0] IDX_SEM = 16'hF904;
  localparam logic [15:0] IDX_OVR0 = 16'hF910;
  localparam logic [15:0] IDX_OVR1 = 16'hF912;
  localparam logic [15:0] IDX_OVR2 = 16'hF914;
  localparam logic [ADR_W-1:0] ADR_CTRL = {IDX_CTRL, 2'h0};
  localparam logic [ADR_W-1:0] ADR_TOP = {IDX_TOP, 2'h0};
  localparam logic [ADR_W-1:0] ADR_SEM = {IDX_SEM, 2'h0};
  localparam logic [ADR_W-1:0] ADR_OVR0 = {IDX_OVR0, 2'h0};
  localparam logic [ADR_W-1:0] ADR_OVR1 = {IDX_OVR1, 2'h0};
  localparam logic [ADR_W-1:0] ADR_OVR2 = {IDX_OVR2, 2'h0};
  // ----------------------------------------------------------------
  // control and status fields
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_IRQ_EN = 7;
  localparam int unsigned CTRL_SEM_WR = 6;
  localparam int unsigned CTRL_ERS_LO = 3;
  localparam int unsigned CTRL_RD_ERR = 0;
  // ----------------------------------------------------------------
  // top address and semaphores
  // ----------------------------------------------------------------
  localparam int unsigned TOP_W = 5;
  localparam logic [TOP_W-1:0] TOP_ROM_SIZE = 5'h02;
  localparam logic [TOP_W-1:0] TOP_FORCED = 5'h00;
  localparam int unsigned SEM_W = 8;
  localparam int unsigned SEM_HOST_W = 4;
  // ----------------------------------------------------------------
  // override map: 16 low 8K bits, then mid and high 64K registers
  // ----------------------------------------------------------------
  localparam int unsigned OVR_REGS = 3;
  localparam int unsigned OVR_REG_W = 16;
  localparam int unsigned OVR_W = 48;
  localparam int unsigned OVR_LOCK_BIT = 7;
  localparam int unsigned OVR_RSV_LO = 16;
  localparam int unsigned OVR_RSV_HI = 17;
  localparam int unsigned UNITS_PER_64K = 8;
  localparam int unsigned HADR_W = 21;
  localparam int unsigned BOOT_W = 8;
  localparam int unsigned UNIT_W = 9;
  typedef enum logic [1:0] {
    SMP_ERS_LONG_WAIT = 2'h0,
    SMP_ERS_READ_ZERO = 2'h1,
    SMP_ERS_ERR_SYNC = 2'h2,
    SMP_ERS_RSVD = 2'h3
  } smp_ers_t;
endpackage

// ==== pkg/smp_ovr_if.sv ====
// signals shared by the controller, the reset-value map and the lookup
// assumes all three sit on the same clock
`timescale 1ns/10ps
`default_nettype none
interface smp_ovr_if;
  import smp_pkg::*;
  logic [TOP_W-1:0] top;
  logic [BOOT_W-1:0] core_boot;
  logic [BOOT_W-1:0] host_boot;
  logic [OVR_W-1:0] rst_val;
  logic [OVR_W-1:0] ro_mask;
  logic [OVR_W-1:0] ovr;
  logic [HADR_W-1:0] addr;
  logic hit;
  modport ctl (output top, core_boot, host_boot, ovr, addr,
               input rst_val, ro_mask, hit);
  modport init (input top, core_boot, host_boot, output rst_val, ro_mask);
  modport look (input ovr, addr, output hit);
endinterface
`default_nettype wire

// ==== rtl/smp_ovr_init.sv ====
// per-bit reset value and read-only mask of the override registers
// assumes boot sizes in 8 Kbyte units, top size in 64 Kbyte units
`timescale 1ns/10ps
`default_nettype none
module smp_ovr_init (
  smp_ovr_if.init g
);
  import smp_pkg::*;
  logic [UNIT_W-1:0] top8;
  logic [UNIT_W-1:0] host_start;
  logic [UNIT_W-1:0] cb;
  logic [UNIT_W-1:0] hb;
  wire [OVR_W-1:0] rv;
  wire [OVR_W-1:0] ro;
  assign top8 = {1'b0, g.top, 3'h0};
  assign cb = {1'b0, g.core_boot};
  assign hb = {1'b0, g.host_boot};
  // a host boot larger than the main block starts at zero
  assign host_start = (hb > top8) ? 9'h000 : top8 - hb;
  // ----------------------------------------------------------------
  // one slice per override bit
  // ----------------------------------------------------------------
  for (genvar b = 0; b < OVR_W; b++) begin : g_bit
    localparam logic [UNIT_W-1:0] ST = (b < 16) ? 9'(b) : 9'(8 * (b - 16));
    localparam logic [UNIT_W-1:0] EN = (b < 16) ? 9'(b + 1) : 9'(ST + 8);
    localparam bit FIXED = (b == OVR_LOCK_BIT);
    localparam bit RSVD = (b == OVR_RSV_LO) || (b == OVR_RSV_HI);
    wire core_blk;
    wire host_blk;
    assign core_blk = ST < cb;
    assign host_blk = !core_blk && ST >= host_start && EN <= top8;
    // core boot reads 1, host boot 0, reserved bits 0, the rest 1
    assign rv[b] = RSVD ? 1'b0 : (FIXED ? 1'b1 : !host_blk);
    assign ro[b] = RSVD || FIXED || core_blk || host_blk;
  end
  assign g.rst_val = rv;
  assign g.ro_mask = ro;
endmodule
`default_nettype wire

// ==== rtl/smp_ovr_look.sv ====
// picks the override bit that guards the host access address
// assumes a 2 Mbyte host window starting at zero
`timescale 1ns/10ps
`default_nettype none
module smp_ovr_look (
  smp_ovr_if.look g
);
  import smp_pkg::*;
  logic [5:0] idx;
  // purely combinational so the bit is settled within the address cycle
  always_comb begin
    if (g.addr[20:17] == 4'h0) begin
      idx = {2'h0, g.addr[16:13]};
    end else if (!g.addr[20]) begin
      idx = {2'h1, g.addr[19:16]};
    end else begin
      idx = {2'h2, g.addr[19:16]};
    end
    g.hit = g.ovr[idx];
  end
endmodule
`default_nettype wire

// ==== rtl/smp_core.sv ====
// core-side control of the shared memory: top size, semaphores, overrides
// assumes a classic wishbone master and host bridge on the same clock
//
// How it works
// - top size register loads its default only on supply power-up reset.
// - five-bit size field counts 64 Kbyte units; top is size times 0x10000.
// - power-up loads size 2, or 0 when force-top-zero is set.
// - size writable only in development environment; bits 7-5 read zero.
// - eight semaphore bits shared by core and host, cleared on reset.
// - semaphore bits 3-0 written by host only, read-only to core.
// - semaphore bits 7-4 written by core only, readable by both.
// - host read allowed only when host protect and override bit clear.
// - override bit set blocks host reads; clear leaves host setting.
// - low register bit i guards 8 Kbyte block i; others 64 Kbyte.
// - mid register bits 15-2 guard 64K blocks 15-2; bits 1-0 zero.
// - high register bits 15-0 guard 64 Kbyte blocks 31 to 16.
// - low register bit 7 is read-only and reads one after reset.
// - overrides reload reset values on reset and on top size change.
// - reset value one for core boot, zero for host boot, else one.
// - core boot, host boot, lock and reserved override bits read-only; others core writable.
// - host semaphore write sets flag; core writes one to clear.
// - flag and enable together drive a level interrupt to the core.
// - host read of blocked block or out-of-range sets read error flag.
// - blocked accesses answered per two-bit error response select.
//
// Local design decision: the Wishbone interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module smp_core (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic por_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [smp_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [smp_pkg::DAT_W-1:0] wb_dat_i,
  output logic [smp_pkg::DAT_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic dev_env_i,
  input wire logic force_top_zero_i,
  input wire logic [smp_pkg::BOOT_W-1:0] core_boot_size_i,
  input wire logic [smp_pkg::BOOT_W-1:0] host_boot_size_i,
  input wire logic host_sem_wr_i,
  input wire logic [smp_pkg::SEM_HOST_W-1:0] host_sem_dat_i,
  input wire logic host_rd_i,
  input wire logic [smp_pkg::HADR_W-1:0] host_addr_i,
  input wire logic host_rd_protect_i,
  input wire logic host_out_of_range_i,
  output logic [smp_pkg::SEM_W-1:0] host_sem_o,
  output logic host_rd_allow_o,
  output logic [1:0] host_err_rsp_o,
  output logic [smp_pkg::TOP_W-1:0] top_size_o,
  output logic irq_o
);
  import smp_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [TOP_W-1:0] top;
    logic [SEM_W-1:0] sem;
    logic [OVR_W-1:0] ovr;
    logic irq_en;
    logic sem_wr;
    logic rd_err;
    logic [1:0] ers;
    logic reload;
    logic ack;
    logic [DAT_W-1:0] rdat;
    logic allow;
    logic [1:0] rsp;
    logic irq;
    logic dev_m;
    logic dev_s;
  } smp_state_t;

  smp_state_t s_q;
  smp_state_t s_d;
  smp_ovr_if ovr_if ();
  logic req;
  logic wr;
  logic blocked;
  logic [OVR_REG_W-1:0] wmask;
  logic [OVR_REG_W-1:0] ro_slice;
  logic [OVR_REG_W-1:0] old_slice;
  logic [OVR_REG_W-1:0] ovr_slice;

  // ----------------------------------------------------------------
  // override reset map and address lookup
  // ----------------------------------------------------------------
  assign ovr_if.top = s_q.top;
  assign ovr_if.core_boot = core_boot_size_i;
  assign ovr_if.host_boot = host_boot_size_i;
  assign ovr_if.ovr = s_q.ovr;
  assign ovr_if.addr = host_addr_i;

  smp_ovr_init u_init (
    .g(ovr_if.init)
  );

  smp_ovr_look u_look (
    .g(ovr_if.look)
  );

  // the host-side bit, the override bit or an out-of-range access is each enough to block
  assign blocked = host_rd_protect_i || ovr_if.hit
                   || host_out_of_range_i;
  assign req = wb_cyc_i && wb_stb_i && !s_q.ack;
  assign wr = req && wb_we_i;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    wmask = '0;
    ro_slice = '0;
    old_slice = '0;
    ovr_slice = '0;
    s_d.ack = req;
    s_d.rdat = '0;
    // strap-like level from outside the clock, two flops before use
    s_d.dev_m = dev_env_i;
    s_d.dev_s = s_q.dev_m;

    if (wr && wb_sel_i[0]) begin
      unique case (wb_adr_i)
        ADR_CTRL: begin
          s_d.irq_en = wb_dat_i[CTRL_IRQ_EN];
          s_d.ers = wb_dat_i[CTRL_ERS_LO +: 2];
          if (wb_dat_i[CTRL_SEM_WR]) begin
            s_d.sem_wr = 1'b0;
          end
          if (wb_dat_i[CTRL_RD_ERR]) begin
            s_d.rd_err = 1'b0;
          end
        end
        ADR_TOP: begin
          if (s_q.dev_s) begin
            s_d.top = wb_dat_i[TOP_W-1:0];
          end
        end
        ADR_SEM: begin
          // host half is left alone on a core write
          s_d.sem[SEM_W-1:SEM_HOST_W] = wb_dat_i[SEM_W-1:SEM_HOST_W];
        end
        default: begin
        end
      endcase
    end

    // override registers, per byte lane, read-only bits kept
    for (int r = 0; r < OVR_REGS; r++) begin
      if (wr && wb_adr_i == ADR_OVR0 + 18'(8 * r)) begin
        ro_slice = ovr_if.ro_mask[r*OVR_REG_W +: OVR_REG_W];
        old_slice = s_q.ovr[r*OVR_REG_W +: OVR_REG_W];
        wmask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}} & ~ro_slice;
        ovr_slice = (old_slice & ~wmask) | (wb_dat_i[15:0] & wmask);
        s_d.ovr[r*OVR_REG_W +: OVR_REG_W] = ovr_slice;
      end
    end

    // a changed top size is seen here and reloads one cycle later
    s_d.reload = s_d.top != s_q.top;
    if (s_q.reload) begin
      s_d.ovr = ovr_if.rst_val;
    end

    // host side events; a set beats a same-cycle clear
    if (host_sem_wr_i) begin
      s_d.sem[SEM_HOST_W-1:0] = host_sem_dat_i;
      s_d.sem_wr = 1'b1;
    end
    if (host_rd_i && blocked) begin
      s_d.rd_err = 1'b1;
    end
    s_d.allow = !blocked;
    s_d.rsp = s_q.ers;
    s_d.irq = s_q.irq_en && s_q.sem_wr;

    // read data, reserved bits read as zero
    if (req && !wb_we_i) begin
      unique case (wb_adr_i)
        ADR_CTRL: begin
          s_d.rdat[CTRL_IRQ_EN] = s_q.irq_en;
          s_d.rdat[CTRL_SEM_WR] = s_q.sem_wr;
          s_d.rdat[CTRL_ERS_LO +: 2] = s_q.ers;
          s_d.rdat[CTRL_RD_ERR] = s_q.rd_err;
        end
        ADR_TOP: s_d.rdat[TOP_W-1:0] = s_q.top;
        ADR_SEM: s_d.rdat[SEM_W-1:0] = s_q.sem;
        ADR_OVR0: s_d.rdat[15:0] = s_q.ovr[15:0];
        ADR_OVR1: s_d.rdat[15:0] = s_q.ovr[31:16];
        ADR_OVR2: s_d.rdat[15:0] = s_q.ovr[47:32];
        default: s_d.rdat = '0;
      endcase
    end

    // ordinary reset keeps the top size, power-up reset reloads it
    if (rst_i || por_i) begin
      s_d = '0;
      s_d.top = s_q.top;
      s_d.ovr = ovr_if.rst_val;
      if (por_i) begin
        s_d.top = force_top_zero_i ? TOP_FORCED : TOP_ROM_SIZE;
        s_d.reload = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    s_q <= s_d;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign wb_dat_o = s_q.rdat;
  assign wb_ack_o = s_q.ack;
  assign host_sem_o = s_q.sem;
  assign host_rd_allow_o = s_q.allow;
  assign host_err_rsp_o = s_q.rsp;
  assign top_size_o = s_q.top;
  assign irq_o = s_q.irq;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i || por_i);

  sequence s_top_change;
    $changed(s_q.top);
  endsequence

  sequence s_reload_done;
    ##1 s_q.ovr == $past(ovr_if.rst_val);
  endsequence

  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_ack_next: assert property (req |=> wb_ack_o)
    else $error("request not acknowledged next cycle");
  a_top_keep: assert property (
    @(posedge clk_i) disable iff (por_i) rst_i |=> $stable(top_size_o))
    else $error("top size changed by ordinary reset");
  a_top_locked: assert property (
    wr && wb_adr_i == ADR_TOP && !s_q.dev_s |=> $stable(top_size_o))
    else $error("top size written outside development");
  a_host_sem: assert property (
    host_sem_wr_i |=> host_sem_o[3:0] == $past(host_sem_dat_i))
    else $error("host semaphore bits not taken");
  a_core_sem_keep: assert property (
    wr && wb_adr_i == ADR_SEM && !host_sem_wr_i
    |=> $stable(host_sem_o[3:0]))
    else $error("core changed host semaphore bits");
  a_core_sem_take: assert property (
    wr && wb_sel_i[0] && wb_adr_i == ADR_SEM
    |=> host_sem_o[7:4] == $past(wb_dat_i[7:4]))
    else $error("core semaphore bits not taken");
  a_sem_flag_set: assert property (
    host_sem_wr_i |=> s_q.sem_wr)
    else $error("semaphore write flag not set");
  a_irq_level: assert property (
    s_q.irq_en && s_q.sem_wr |=> irq_o)
    else $error("interrupt missing while flag and enable set");
  a_irq_cause: assert property (
    irq_o |-> $past(s_q.irq_en) && $past(s_q.sem_wr))
    else $error("interrupt without cause");
  a_rd_err_set: assert property (
    host_rd_i && blocked |=> s_q.rd_err)
    else $error("read error flag not set");
  a_rd_allow: assert property (
    host_rd_allow_o |-> !$past(ovr_if.hit) && !$past(host_rd_protect_i))
    else $error("read allowed on a protected block");
  a_ovr_reload: assert property (
    s_top_change |-> s_reload_done)
    else $error("overrides not reloaded after top change");
  a_lock_bit: assert property (s_q.ovr[OVR_LOCK_BIT])
    else $error("locked override bit not one");
  a_rsvd_zero: assert property (
    s_q.ovr[OVR_RSV_HI:OVR_RSV_LO] == 2'h0)
    else $error("reserved override bits not zero");

endmodule
`default_nettype wire

// ==== tb/smp_host_model.sv ====
// host-side stand-in: semaphore writes and read attempts through the bridge
// assumes the core block's clock; every request changes just after an edge
`timescale 1ns/10ps
`default_nettype none
module smp_host_model (
  input wire logic clk_i,
  output logic sem_wr_o,
  output logic [smp_pkg::SEM_HOST_W-1:0] sem_dat_o,
  output logic rd_o,
  output logic [smp_pkg::HADR_W-1:0] addr_o,
  output logic protect_o,
  output logic oor_o
);
  import smp_pkg::*;
  initial begin
    sem_wr_o = 1'b0;
    sem_dat_o = 4'h5;
    rd_o = 1'b0;
    addr_o = '0;
    protect_o = 1'b0;
    oor_o = 1'b0;
  end
  // ----------------------------------------------------------------
  // host writes only its own four semaphore bits
  // ----------------------------------------------------------------
  task automatic write_sem(input logic [SEM_HOST_W-1:0] dat);
    @(posedge clk_i);
    sem_wr_o <= 1'b1;
    sem_dat_o <= dat;
    @(posedge clk_i);
    sem_wr_o <= 1'b0;
    // released data shows garbage, so a late sample is caught
    sem_dat_o <= ~dat;
  endtask
  // ----------------------------------------------------------------
  // one read attempt; address and qualifiers scramble afterwards
  // ----------------------------------------------------------------
  task automatic read(input logic [HADR_W-1:0] a, input logic prot,
      input logic oor);
    @(posedge clk_i);
    rd_o <= 1'b1;
    addr_o <= a;
    protect_o <= prot;
    oor_o <= oor;
    @(posedge clk_i);
    rd_o <= 1'b0;
    addr_o <= ~a;
    protect_o <= ~prot;
    oor_o <= ~oor;
  endtask
endmodule
`default_nettype wire

// ==== tb/smp_core_tb.sv ====
// self-checking bench of the core-side shared memory protection block
// assumes one 100 MHz clock; registers reached over classic wishbone
`timescale 1ns/10ps
`default_nettype none
module smp_core_tb;
  import smp_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic por_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [ADR_W-1:0] adr = '0;
  logic [3:0] sel = 4'h0;
  logic [DAT_W-1:0] dat_w = '0;
  logic [DAT_W-1:0] dat_r;
  logic ack;
  logic dev_env = 1'b0;
  logic force_zero = 1'b0;
  logic [BOOT_W-1:0] core_boot = 8'h02;
  logic [BOOT_W-1:0] host_boot = 8'h08;
  logic h_wr, h_rd, h_prot, h_oor, allow, irq;
  logic [SEM_HOST_W-1:0] h_dat;
  logic [HADR_W-1:0] h_addr;
  logic [SEM_W-1:0] sem;
  logic [1:0] rsp;
  logic [TOP_W-1:0] top;
  int n_fail = 0;
  int total_checks = 0;
  always #5 clk_i = ~clk_i;
  smp_host_model i_host (.clk_i(clk_i), .sem_wr_o(h_wr), .sem_dat_o(h_dat),
    .rd_o(h_rd), .addr_o(h_addr), .protect_o(h_prot), .oor_o(h_oor));
  smp_core i_dut (.clk_i(clk_i), .rst_i(rst_i), .por_i(por_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack),
    .dev_env_i(dev_env), .force_top_zero_i(force_zero),
    .core_boot_size_i(core_boot), .host_boot_size_i(host_boot),
    .host_sem_wr_i(h_wr), .host_sem_dat_i(h_dat), .host_rd_i(h_rd),
    .host_addr_i(h_addr), .host_rd_protect_i(h_prot),
    .host_out_of_range_i(h_oor), .host_sem_o(sem), .host_rd_allow_o(allow),
    .host_err_rsp_o(rsp), .top_size_o(top), .irq_o(irq));
  // ----------------------------------------------------------------
  // shared helpers
  // ----------------------------------------------------------------
  task automatic conclude();
    $display("checks %0d errors %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp,
      input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // no fixed latency assumed: wait for ack under a bounded count
  task automatic wb_xfer(input logic w, input logic [ADR_W-1:0] a,
      input logic [DAT_W-1:0] d, output logic [DAT_W-1:0] r);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'h3;
    dat_w <= d;
    // ack and read data are taken at the rising edge that samples ack high
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) begin
      n_fail++;
      $display("Error wb_ack expected 1 seen %b", ack);
    end
    r = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic wr(input logic [ADR_W-1:0] a, input logic [31:0] d);
    logic [DAT_W-1:0] r;
    wb_xfer(1'b1, a, d, r);
  endtask
  task automatic rd_chk(input string s, input logic [ADR_W-1:0] a,
      input logic [31:0] e);
    logic [DAT_W-1:0] r;
    wb_xfer(1'b0, a, '0, r);
    check(s, e, r);
  endtask
  task automatic host_chk(input logic [HADR_W-1:0] a, input logic p,
      input logic e);
    i_host.read(a, p, 1'b0);
    #1;
    check("host_rd_allow", {31'h0, e}, {31'h0, allow});
  endtask
  task automatic do_reset(input logic p);
    @(posedge clk_i);
    rst_i <= 1'b1;
    por_i <= p;
    @(posedge clk_i);
    rst_i <= 1'b0;
    por_i <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_por();
    rd_chk("top", ADR_TOP, 32'h02);
    rd_chk("ovr0", ADR_OVR0, 32'h00FF);
    rd_chk("ovr1", ADR_OVR1, 32'hFFFC);
    rd_chk("ovr2", ADR_OVR2, 32'hFFFF);
    rd_chk("sem", ADR_SEM, 32'h00);
    rd_chk("gap", 18'h00040, 32'h0);
  endtask
  task automatic t_ro_bits();
    wr(ADR_OVR0, 32'h0000);
    rd_chk("ovr0", ADR_OVR0, 32'h0083);
    wr(ADR_OVR0, 32'hFFFF);
    rd_chk("ovr0", ADR_OVR0, 32'h00FF);
    wr(ADR_OVR1, 32'h0003);
    rd_chk("ovr1", ADR_OVR1, 32'h0000);
  endtask
  task automatic t_host_rd();
    host_chk(21'h10000, 1'b0, 1'b1);
    host_chk(21'h10000, 1'b1, 1'b0);
    host_chk(21'h00000, 1'b0, 1'b0);
    host_chk(21'h0E000, 1'b0, 1'b0);
    host_chk(21'h20000, 1'b0, 1'b1);
    wr(ADR_OVR2, 32'hFFFE);
    host_chk(21'h100000, 1'b0, 1'b1);
    host_chk(21'h110000, 1'b0, 1'b0);
    rd_chk("ctrl", ADR_CTRL, 32'h01);
    wr(ADR_CTRL, 32'h01);
    rd_chk("ctrl", ADR_CTRL, 32'h00);
    i_host.read(21'h10000, 1'b0, 1'b1);
    rd_chk("ctrl", ADR_CTRL, 32'h01);
    wr(ADR_CTRL, 32'h01);
  endtask
  task automatic t_sem();
    wr(ADR_SEM, 32'hFF);
    rd_chk("sem", ADR_SEM, 32'hF0);
    i_host.write_sem(4'hA);
    #1;
    check("host_sem", 32'hFA, {24'h0, sem});
    rd_chk("ctrl", ADR_CTRL, 32'h40);
    wr(ADR_CTRL, 32'h80);
    @(posedge clk_i);
    #1;
    check("irq", 32'h1, {31'h0, irq});
    rd_chk("ctrl", ADR_CTRL, 32'hC0);
    wr(ADR_CTRL, 32'hC0);
    @(posedge clk_i);
    #1;
    check("irq", 32'h0, {31'h0, irq});
    wr(ADR_CTRL, 32'h00);
    do_reset(1'b0);
    rd_chk("sem", ADR_SEM, 32'h00);
  endtask
  task automatic t_err_rsp();
    for (int c = 0; c < 4; c++) begin
      wr(ADR_CTRL, 32'(c) << CTRL_ERS_LO);
      @(posedge clk_i);
      #1;
      check("err_rsp", 32'(c), {30'h0, rsp});
    end
    wr(ADR_CTRL, 32'h00);
  endtask
  task automatic t_top();
    wr(ADR_TOP, 32'h04);
    rd_chk("top", ADR_TOP, 32'h02);
    dev_env <= 1'b1;
    // the environment input is resynchronised, give it time to land
    repeat (4) @(posedge clk_i);
    wr(ADR_TOP, 32'hE4);
    repeat (3) @(posedge clk_i);
    rd_chk("top", ADR_TOP, 32'h04);
    check("top_size", 32'h04, {27'h0, top});
    rd_chk("ovr0", ADR_OVR0, 32'hFFFF);
    rd_chk("ovr1", ADR_OVR1, 32'hFFF4);
    host_chk(21'h30000, 1'b0, 1'b1);
    host_chk(21'h20000, 1'b0, 1'b0);
    dev_env <= 1'b0;
    do_reset(1'b0);
    rd_chk("top", ADR_TOP, 32'h04);
  endtask
  task automatic t_force();
    force_zero <= 1'b1;
    do_reset(1'b1);
    rd_chk("top", ADR_TOP, 32'h00);
    force_zero <= 1'b0;
    do_reset(1'b1);
    rd_chk("top", ADR_TOP, 32'h02);
  endtask
  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    por_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    t_por();
    t_ro_bits();
    t_host_rd();
    t_sem();
    t_err_rsp();
    t_top();
    t_force();
    conclude();
  end
  // whole run is well under two thousand cycles
  initial begin
    repeat (20000) @(posedge clk_i);
    n_fail++;
    $display("Error watchdog expected done seen hang");
    conclude();
  end
endmodule
`default_nettype wire
